// file: common/mgmt_pkg.sv
// Constants for the management pin block: frame layout, register map and timing.
// Assumes a 40 MHz system clock and a management clock well below half of it.
package mgmt_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS    = 25;
    localparam int MDC_MAX_MHZ      = 25;
    localparam int RESET_MIN_NS     = 1000;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Frame layout
    localparam logic [5:0] PRE_LEN  = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0d;
    localparam logic [4:0] DAT_LAST = 5'h0f;
    localparam logic [1:0] ST_CODE  = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [4:0] PHY_ADDR = 5'h01;

    // ==========================================================
    // Register map
    localparam logic [4:0]  REG_CTRL   = 5'h00;
    localparam logic [4:0]  REG_STAT   = 5'h01;
    localparam logic [4:0]  REG_IEN    = 5'h12;
    localparam logic [4:0]  REG_ISTAT  = 5'h13;
    localparam logic [4:0]  REG_CFG    = 5'h1e;
    localparam int          CTRL_RESET = 15;
    localparam int          CTRL_PD    = 11;
    localparam int          CFG_IRQ    = 7;
    localparam int          STAT_PD    = 1;
    localparam int          STAT_IRQ   = 0;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h0800;
    localparam logic [15:0] IEN_RST    = 16'h0000;
    localparam logic [15:0] CFG_RST    = 16'h0000;
    localparam logic [15:0] CFG_WMASK  = 16'h0080;

    // ==========================================================
    // Synchroniser lanes and their idle levels
    localparam int         SYNC_W   = 3;
    localparam int         LANE_MDC = 0;
    localparam int         LANE_MDI = 1;
    localparam int         LANE_PIN = 2;
    localparam logic [2:0] SYNC_RST = 3'h6;

    typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DATA} mgmt_state_t;

endpackage

// file: hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes each lane is a slow level; a change is taken when stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
    parameter int              W   = 3,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_st_t;

    sync_st_t     r;
    sync_st_t     n;
    logic [W-1:0] filt;

    // ==========================================================
    // Per-lane filter: follow the input only when the late stages agree.
    for (genvar i = 0; i < W; i++) begin : g_lane
        assign filt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
    end

    // Next state of the shift chain.
    always_comb begin
        n    = r;
        n.s1 = d_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q  = filt;
    end

    // State register.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= n;
        end
    end

    assign q_o = r.q;

endmodule

// file: hdl/mgmt_pins.sv
// Management serial slave with dual-use interrupt or power-down pin.
// Assumes the pins arrive asynchronously and the station keeps its own timing.
`timescale 1ns/100ps
module mgmt_pins (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    input  wire logic        irq_or_sleep_pin_i,
    output logic             irq_or_sleep_pin_o,
    output logic             irq_or_sleep_pin_oe_o,
    input  wire logic [15:0] event_i,
    output logic             power_down_o
);
    import mgmt_pkg::*;

    typedef struct packed {
        mgmt_state_t state;
        logic [5:0]  ones;
        logic [4:0]  cnt;
        logic [13:0] hdr;
        logic [15:0] shift;
        logic        rd;
        logic        mdc_prev;
        logic        mdo;
        logic        mdoe;
        logic        pd;
        logic        irq_oe;
        logic [15:0] ctrl;
        logic [15:0] ien;
        logic [15:0] istat;
        logic [15:0] cfg;
    } mgmt_st_t;

    mgmt_st_t            r;
    mgmt_st_t            n;
    logic [SYNC_W-1:0]   sync_q;
    logic                mdc_f;
    logic                mdi_f;
    logic                pin_f;
    logic                mdc_rise;
    logic [13:0]         hdr_full;
    logic [15:0]         wdata;
    logic [15:0]         clr;
    logic                irq_mode;
    logic                pending;

    // ==========================================================
    // Pin synchronisation.
    pin_sync #(
        .W   (SYNC_W),
        .RST (SYNC_RST)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      ({irq_or_sleep_pin_i, mdio_i, mdc_i}),
        .q_o      (sync_q)
    );

    // Filtered pins and the management clock rising edge.
    assign mdc_f    = sync_q[LANE_MDC];
    assign mdi_f    = sync_q[LANE_MDI];
    assign pin_f    = sync_q[LANE_PIN];
    assign mdc_rise = mdc_f & ~r.mdc_prev;
    assign hdr_full = {r.hdr[12:0], mdi_f};
    assign wdata    = {r.shift[14:0], mdi_f};
    assign irq_mode = r.cfg[CFG_IRQ];
    assign pending  = |(r.istat & r.ien);

    // Register read multiplexer.
    function automatic logic [15:0] read_reg(input mgmt_st_t s, input logic [4:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            REG_CTRL:  v = s.ctrl;
            REG_STAT:  begin
                v[STAT_PD]  = s.pd;
                v[STAT_IRQ] = |(s.istat & s.ien);
            end
            REG_IEN:   v = s.ien;
            REG_ISTAT: v = s.istat;
            REG_CFG:   v = s.cfg;
            default:   v = 16'h0000;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Frame engine, register file and pin logic.
    always_comb begin
        n          = r;
        clr        = 16'h0000;
        n.mdc_prev = mdc_f;
        if (mdc_rise) begin
            case (r.state)
                S_PRE: begin
                    if (mdi_f) begin
                        if (r.ones != PRE_LEN) begin
                            n.ones = r.ones + 6'h01;
                        end
                    end else if (r.ones == PRE_LEN) begin
                        n.state = S_HDR;
                        n.hdr   = 14'h0000;
                        n.cnt   = 5'h01;
                    end else begin
                        n.ones = 6'h00;
                    end
                end
                S_HDR: begin
                    n.hdr = hdr_full;
                    n.cnt = r.cnt + 5'h01;
                    if (r.cnt == HDR_LAST) begin
                        n.cnt  = 5'h00;
                        n.ones = 6'h00;
                        if (hdr_full[13:12] == ST_CODE && hdr_full[9:5] == PHY_ADDR &&
                            (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE)) begin
                            n.state = S_TA;
                            n.rd    = (hdr_full[11:10] == OP_READ);
                            if (hdr_full[11:10] == OP_READ) begin
                                n.shift = read_reg(r, hdr_full[4:0]);
                                if (hdr_full[4:0] == REG_ISTAT) begin
                                    clr = r.istat;
                                end
                            end
                        end else begin
                            n.state = S_PRE;
                        end
                    end
                end
                S_TA: begin
                    n.cnt = r.cnt + 5'h01;
                    if (r.rd && r.cnt == 5'h00) begin
                        n.mdoe = 1'b1;
                        n.mdo  = 1'b0;
                    end
                    if (r.cnt != 5'h00) begin
                        n.state = S_DATA;
                        n.cnt   = 5'h00;
                        if (r.rd) begin
                            n.mdo   = r.shift[15];
                            n.shift = {r.shift[14:0], 1'b0};
                        end
                    end
                end
                S_DATA: begin
                    n.cnt = r.cnt + 5'h01;
                    if (r.rd) begin
                        n.mdo   = r.shift[15];
                        n.shift = {r.shift[14:0], 1'b0};
                    end else begin
                        n.shift = wdata;
                    end
                    if (r.cnt == DAT_LAST) begin
                        n.state = S_PRE;
                        n.mdoe  = 1'b0;
                        n.mdo   = 1'b0;
                        n.cnt   = 5'h00;
                        if (!r.rd) begin
                            case (r.hdr[4:0])
                                REG_CTRL: begin
                                    if (wdata[CTRL_RESET]) begin
                                        n.ctrl = CTRL_RST;
                                        n.ien  = IEN_RST;
                                        n.cfg  = CFG_RST;
                                    end else begin
                                        n.ctrl = wdata & CTRL_WMASK;
                                    end
                                end
                                REG_IEN: n.ien = wdata;
                                REG_CFG: n.cfg = wdata & CFG_WMASK;
                                default: n.ctrl = n.ctrl;
                            endcase
                        end
                    end
                end
                default: n.state = S_PRE;
            endcase
        end
        // Sticky interrupt flags: a new event wins over the read clear.
        n.istat  = (r.istat & ~clr) | event_i;
        // Pin is the power-down input unless interrupt mode is set.
        n.pd     = r.ctrl[CTRL_PD] | (~irq_mode & ~pin_f);
        n.irq_oe = irq_mode & pending;
    end

    // State register; reset restores every register default.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{state: S_PRE, ctrl: CTRL_RST, ien: IEN_RST, cfg: CFG_RST,
                   default: '0};
        end else begin
            r <= n;
        end
    end

    // Output drive; the interrupt pin only ever pulls low.
    assign mdio_o                = r.mdo;
    assign mdio_oe_o             = r.mdoe;
    assign irq_or_sleep_pin_o    = 1'b0;
    assign irq_or_sleep_pin_oe_o = r.irq_oe;
    assign power_down_o          = r.pd;

    // ==========================================================
    // Assertions.
    a_state_on_mdc: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (r.state != $past(r.state)) |-> $past(mdc_rise))
        else $error("Frame state moved without a management clock edge.");

    a_mdio_owner: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mdio_oe_o |-> (r.rd && (r.state == S_TA || r.state == S_DATA)))
        else $error("Data line driven outside a read turnaround or data phase.");

    a_pin_default: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !irq_mode |=> !irq_or_sleep_pin_oe_o)
        else $error("Dual-use pin driven while in power-down input mode.");

    a_pd_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!irq_mode && !pin_f) |=> power_down_o)
        else $error("Low dual-use pin did not enter power-down.");

    a_pd_access: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (power_down_o && mdc_rise && r.state == S_HDR && r.cnt == HDR_LAST &&
         hdr_full[13:12] == ST_CODE && hdr_full[9:5] == PHY_ADDR &&
         hdr_full[11:10] == OP_READ) |=> (r.state == S_TA))
        else $error("Register access refused during power-down.");

    a_open_drain: assert property (@(posedge clk_i) disable iff (!resetn_i)
        irq_or_sleep_pin_oe_o |-> (!irq_or_sleep_pin_o && $past(irq_mode)))
        else $error("Interrupt pin driven high or outside interrupt mode.");

    a_reset_vals: assert property (@(posedge clk_i)
        !resetn_i |-> (r.ctrl == CTRL_RST && r.cfg == CFG_RST && r.ien == IEN_RST &&
                       r.istat == 16'h0000 && !mdio_oe_o))
        else $error("Register not at its default during reset.");

    a_reset_idle: assert property (@(posedge clk_i)
        !resetn_i |-> (r.state == S_PRE && r.ones == 6'h00 && !power_down_o))
        else $error("Frame engine not reinitialised during reset.");

    a_read_ta: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mdc_rise && r.state == S_TA && r.rd && r.cnt == 5'h00) |=>
        (mdio_oe_o && !mdio_o))
        else $error("Read turnaround second bit not driven low.");

    a_irq_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        irq_or_sleep_pin_oe_o == $past(irq_mode && pending))
        else $error("Interrupt pin level does not follow pending enabled flags.");

endmodule

// file: dv/mgmt_station.sv
// Behavioural management station that frames register reads and writes on the serial link.
// Assumes the bench resolves the shared data line with a pull-up and calls frame() itself.
`timescale 1ns/100ps
module mgmt_station (
    input  wire logic        mdio_i,
    output logic             mdc_o,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    output logic             rd_done_o,
    output logic [15:0]      rd_data_o
);
    import mgmt_pkg::*;

    // ==========================================================
    // Idle state: the clock stands low and the data line is released.
    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b0;
        mdio_oe_o = 1'b0;
        rd_done_o = 1'b0;
        rd_data_o = 16'h0000;
    end

    // One bit slot: data changes after the falling edge and is sampled on the rising edge.
    task automatic bit_io(input logic b, input logic drv, input int half, output logic s);
        mdio_oe_o = drv;
        mdio_o    = drv & b;
        #(half);
        mdc_o = 1'b1;
        s = mdio_i;
        #(half);
        mdc_o = 1'b0;
    endtask

    // A whole frame, most significant bit first; a read releases the line from turnaround on.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, input int pre, input int half);
        logic [13:0] hdr;
        logic        rd;
        logic        s;
        int          i;
        hdr = {ST_CODE, op, pa, ra};
        rd  = (op == OP_READ);
        #3.7;
        for (i = 0; i < pre; i++) begin
            bit_io(1'b1, 1'b1, half, s);
        end
        for (i = 13; i >= 0; i--) begin
            bit_io(hdr[i], 1'b1, half, s);
        end
        bit_io(1'b1, !rd, half, s);
        bit_io(1'b0, !rd, half, s);
        for (i = 15; i >= 0; i--) begin
            bit_io(wd[i], !rd, half, s);
            rd_data_o[i] = s;
        end
        // Idle gap lets the device let go of the line before the next frame.
        mdio_oe_o = 1'b0;
        if (rd) begin
            rd_done_o = 1'b1;
            #25;
            rd_done_o = 1'b0;
        end
        #(2 * half);
    endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the management pin block, driven by a behavioural station.
// Assumes pull-ups on the shared data line and on the dual-use pin.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    import mgmt_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_i;
    logic        resetn_i;
    logic        mdc;
    logic        mdio_w;
    logic        st_o;
    logic        st_oe;
    logic        dut_o;
    logic        dut_oe;
    logic        pin_w;
    logic        pin_o;
    logic        pin_oe;
    logic        pin_ext;
    logic [15:0] event_i;
    logic        pd;
    logic        rd_done;
    logic [15:0] rd_data;
    logic [31:0] seed;
    logic [15:0] exp_q[$];
    int          mismatches;
    int          cmp_count;

    // Wire resolution: whoever enables drives, otherwise the pull-up wins.
    assign mdio_w = st_oe ? st_o : (dut_oe ? dut_o : 1'b1);
    assign pin_w  = pin_oe ? 1'b0 : pin_ext;

    // Clock generator.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    mgmt_pins dut (
        .clk_i                 (clk_i),
        .resetn_i              (resetn_i),
        .mdc_i                 (mdc),
        .mdio_i                (mdio_w),
        .mdio_o                (dut_o),
        .mdio_oe_o             (dut_oe),
        .irq_or_sleep_pin_i    (pin_w),
        .irq_or_sleep_pin_o    (pin_o),
        .irq_or_sleep_pin_oe_o (pin_oe),
        .event_i               (event_i),
        .power_down_o          (pd)
    );

    mgmt_station st (
        .mdio_i    (mdio_w),
        .mdc_o     (mdc),
        .mdio_o    (st_o),
        .mdio_oe_o (st_oe),
        .rd_done_o (rd_done),
        .rd_data_o (rd_data)
    );

    // ==========================================================
    // Tasks
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic do_reset();
        int i;
        @(posedge clk_i);
        resetn_i <= 1'b0;
        for (i = 0; i < RESET_MIN_CYCLES; i++) begin
            @(posedge clk_i);
        end
        @(negedge clk_i);
        `CHK({dut_oe, pin_oe, pd}, 3'h0)
        @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask

    // Bounded wait on power-down (sel 0) or the pin pull-down (sel 1).
    task automatic wait_for(input int sel, input logic v);
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_i);
            if ((sel == 0 ? pd : pin_oe) === v) break;
        end
        `CHK(sel == 0 ? pd : pin_oe, v)
        if (i == 40) end_sim();
    endtask

    // A read notes its expected data before the frame goes out.
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] d,
                        input logic [4:0] pa = PHY_ADDR, input int pre = 32,
                        input int half = 100);
        if (op == OP_READ) exp_q.push_back(d);
        st.frame(op, pa, ra, d, pre, half);
    endtask

    task automatic pulse(input logic [15:0] v);
        @(posedge clk_i);
        event_i <= v;
        @(posedge clk_i);
        event_i <= 16'h0000;
    endtask

    // ==========================================================
    // Checkers: read results against notes, and the wires every cycle.
    initial begin
        logic [15:0] e;
        forever begin
            @(posedge rd_done);
            `CHK(exp_q.size() > 0, 1'b1)
            e = exp_q.pop_front();
            `CHK(rd_data, e)
        end
    end

    always @(negedge clk_i) begin
        if (resetn_i) begin
            `CHK(st_oe & dut_oe, 1'b0)
            `CHK(pin_o, 1'b0)
        end
    end

    // Hang guard.
    initial begin
        #2_000_000;
        mismatches++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] ien;
        int          i;
        resetn_i   = 1'b0;
        pin_ext    = 1'b1;
        event_i    = 16'h0000;
        mismatches = 0;
        cmp_count  = 0;
        seed       = 32'h000012c4;
        do_reset();
        `CHK(pd, 1'b0)
        xfer(OP_READ, REG_CTRL, CTRL_RST);
        xfer(OP_READ, REG_IEN, IEN_RST);
        xfer(OP_READ, REG_CFG, CFG_RST);
        // Pin low powers down while register access stays alive.
        @(posedge clk_i) pin_ext <= 1'b0;
        wait_for(0, 1'b1);
        xfer(OP_READ, REG_STAT, 16'h0002);
        xfer(OP_WRITE, REG_CTRL, 16'h0800);
        @(posedge clk_i) pin_ext <= 1'b1;
        xfer(OP_READ, REG_CTRL, 16'h0800);
        `CHK(pd, 1'b1)
        xfer(OP_WRITE, REG_CTRL, 16'h0000);
        wait_for(0, 1'b0);
        // Interrupt mode: masked event stays quiet, enabled one pulls low until read.
        r   = rnd();
        ien = (r[15:0] | 16'h0001) & 16'h7fff;
        xfer(OP_WRITE, REG_IEN, ien);
        xfer(OP_WRITE, REG_CFG, 16'h0080);
        pulse(16'h8000);
        repeat (4) @(negedge clk_i);
        `CHK(pin_oe, 1'b0)
        pulse(16'h0001);
        wait_for(1, 1'b1);
        repeat (8) @(negedge clk_i);
        `CHK(pd, 1'b0)
        xfer(OP_READ, REG_STAT, 16'h0001);
        xfer(OP_READ, REG_ISTAT, 16'h8001);
        wait_for(1, 1'b0);
        xfer(OP_READ, REG_ISTAT, 16'h0000);
        xfer(OP_WRITE, REG_CFG, 16'h0000);
        // Refused frames change nothing and never drive the line.
        xfer(OP_WRITE, REG_IEN, 16'h1234, PHY_ADDR, 31);
        xfer(OP_WRITE, REG_IEN, 16'h1234, 5'h02);
        xfer(2'h3, REG_IEN, 16'h1234);
        xfer(2'h0, REG_IEN, 16'h1234);
        xfer(OP_READ, REG_IEN, 16'hffff, 5'h02);
        xfer(OP_READ, REG_IEN, ien, PHY_ADDR, 32, 400);
        // Random round trips, back to back.
        for (i = 0; i < 4; i++) begin
            r = rnd();
            xfer(OP_WRITE, REG_IEN, r[15:0]);
            xfer(OP_READ, REG_IEN, r[15:0]);
        end
        // Soft reset restores the enables and self-clears; unmapped reads return zero.
        xfer(OP_WRITE, REG_CTRL, 16'h8800);
        xfer(OP_READ, REG_IEN, IEN_RST);
        xfer(OP_READ, REG_CTRL, CTRL_RST);
        xfer(OP_READ, 5'h05, 16'h0000);
        xfer(OP_WRITE, REG_IEN, r[15:0] | 16'h0001);
        // Mid-run reset clears soft power-down and the enables.
        xfer(OP_WRITE, REG_CTRL, 16'h0800);
        do_reset();
        `CHK(pd, 1'b0)
        xfer(OP_READ, REG_CTRL, CTRL_RST);
        xfer(OP_READ, REG_IEN, IEN_RST);
        `CHK(exp_q.size(), 0)
        end_sim();
    end
endmodule
